// ---- include/vector_pkg.sv ----
package vector_pkg;

  localparam int VEC_W  = 5;
  localparam int ADDR_W = 16;
  localparam int NUM_SRC = 18;

  // Vector numbers per source
  localparam logic [VEC_W-1:0] VEC_RESET     = 5'h00;
  localparam logic [VEC_W-1:0] VEC_SYS_LO    = 5'h01;
  localparam logic [VEC_W-1:0] VEC_SYS_HI    = 5'h06;
  localparam logic [VEC_W-1:0] VEC_NMI       = 5'h07;
  localparam logic [VEC_W-1:0] VEC_TRAP0     = 5'h08;
  localparam logic [VEC_W-1:0] VEC_BREAK     = 5'h0c;
  localparam logic [VEC_W-1:0] VEC_SLEEP     = 5'h0d;
  localparam logic [VEC_W-1:0] VEC_EXT0      = 5'h0e;
  localparam logic [VEC_W-1:0] VEC_EXT3      = 5'h11;
  localparam logic [VEC_W-1:0] VEC_WAKEUP    = 5'h12;
  localparam logic [VEC_W-1:0] VEC_SYS_20    = 5'h14;
  localparam logic [VEC_W-1:0] VEC_TIMER_W   = 5'h15;
  localparam logic [VEC_W-1:0] VEC_TIMER_V   = 5'h16;
  localparam logic [VEC_W-1:0] VEC_SERIAL    = 5'h17;
  localparam logic [VEC_W-1:0] VEC_CONV_END  = 5'h19;

  localparam logic [VEC_W-1:0]  VEC_RST_VAL  = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST_VAL = 16'h0000;

  typedef struct packed {
    logic       reset;       // Pin or watchdog
    logic       nmi;
    logic [3:0] trap;
    logic       addr_break;
    logic       sleep_trans;
    logic       ext_request_zero;
    logic       ext_request_three;
    logic [5:0] wakeup_pins;
    logic [4:0] timer_w;
    logic [2:0] timer_v;
    logic [3:0] serial_unit;
    logic       conv_end;
  } request_type;

  typedef struct packed {
    logic              valid;
    logic [VEC_W-1:0]  number;
    logic [ADDR_W-1:0] address;
  } grant_type;

endpackage : vector_pkg

// ---- src/exception_vector_priority.sv ----
`timescale 1ns/1ps

module exception_vector_priority
  import vector_pkg::*;
#(
  parameter int VECTOR_WIDTH  = VEC_W,
  parameter int ADDRESS_WIDTH = ADDR_W
)
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire request_type req,
  input  wire logic        ccr_int_mask,
  input  wire logic        flash_busy,
  output grant_type        grant_ff
);

  // Slot 0 is the strongest; traps get one slot each so the lowest wins
  localparam int NUM_SLOTS = 15;

  typedef enum logic [1:0] {
    CLASS_RESET    = 2'b00,
    CLASS_UNMASKED = 2'b01,
    CLASS_MASKABLE = 2'b10
  } slot_class_type;

  grant_type            nxt_grant;
  logic [VEC_W-1:0]     nxt_number;
  logic                 nxt_any;
  wire  [NUM_SLOTS-1:0] raised;
  wire  [NUM_SLOTS-1:0] allowed;
  wire  [NUM_SLOTS-1:0] eligible;
  wire  [NUM_SLOTS-1:0] taken_above;
  wire  [NUM_SLOTS-1:0] winner;

  function automatic logic [ADDR_W-1:0] vec_addr(
    input logic [VEC_W-1:0] num
  );
    vec_addr = {{(ADDR_W-VEC_W-1){1'b0}}, num, 1'b0};
  endfunction : vec_addr

  function automatic logic is_reserved(
    input logic [VEC_W-1:0] num
  );
    is_reserved = (num >= VEC_SYS_LO && num <= VEC_SYS_HI) || num == VEC_SYS_20;
  endfunction : is_reserved

  function automatic logic [VEC_W-1:0] slot_vector(
    input int slot
  );
    case (slot)
      0: begin
        slot_vector = VEC_RESET;
      end
      1: begin
        slot_vector = VEC_NMI;
      end
      2: begin
        slot_vector = VEC_TRAP0;
      end
      3: begin
        slot_vector = VEC_TRAP0 + 5'h01;
      end
      4: begin
        slot_vector = VEC_TRAP0 + 5'h02;
      end
      5: begin
        slot_vector = VEC_TRAP0 + 5'h03;
      end
      6: begin
        slot_vector = VEC_BREAK;
      end
      7: begin
        slot_vector = VEC_SLEEP;
      end
      8: begin
        slot_vector = VEC_EXT0;
      end
      9: begin
        slot_vector = VEC_EXT3;
      end
      10: begin
        slot_vector = VEC_WAKEUP;
      end
      11: begin
        slot_vector = VEC_TIMER_W;
      end
      12: begin
        slot_vector = VEC_TIMER_V;
      end
      13: begin
        slot_vector = VEC_SERIAL;
      end
      14: begin
        slot_vector = VEC_CONV_END;
      end
      default: begin
        slot_vector = VEC_RESET;
      end
    endcase
  endfunction : slot_vector

  // Break, sleep and traps are core events, so the mask bit leaves them alone
  function automatic slot_class_type slot_class(
    input int slot
  );
    case (slot)
      0: begin
        slot_class = CLASS_RESET;
      end
      1: begin
        slot_class = CLASS_UNMASKED;
      end
      2: begin
        slot_class = CLASS_UNMASKED;
      end
      3: begin
        slot_class = CLASS_UNMASKED;
      end
      4: begin
        slot_class = CLASS_UNMASKED;
      end
      5: begin
        slot_class = CLASS_UNMASKED;
      end
      6: begin
        slot_class = CLASS_UNMASKED;
      end
      7: begin
        slot_class = CLASS_UNMASKED;
      end
      8: begin
        slot_class = CLASS_MASKABLE;
      end
      9: begin
        slot_class = CLASS_MASKABLE;
      end
      10: begin
        slot_class = CLASS_MASKABLE;
      end
      11: begin
        slot_class = CLASS_MASKABLE;
      end
      12: begin
        slot_class = CLASS_MASKABLE;
      end
      13: begin
        slot_class = CLASS_MASKABLE;
      end
      14: begin
        slot_class = CLASS_MASKABLE;
      end
      default: begin
        slot_class = CLASS_MASKABLE;
      end
    endcase
  endfunction : slot_class

  // Grouped sources fold onto one slot
  function automatic logic slot_request(
    input request_type r,
    input int          slot
  );
    case (slot)
      0: begin
        slot_request = r.reset;
      end
      1: begin
        slot_request = r.nmi;
      end
      2: begin
        slot_request = r.trap[0];
      end
      3: begin
        slot_request = r.trap[1];
      end
      4: begin
        slot_request = r.trap[2];
      end
      5: begin
        slot_request = r.trap[3];
      end
      6: begin
        slot_request = r.addr_break;
      end
      7: begin
        slot_request = r.sleep_trans;
      end
      8: begin
        slot_request = r.ext_request_zero;
      end
      9: begin
        slot_request = r.ext_request_three;
      end
      10: begin
        slot_request = |r.wakeup_pins;
      end
      11: begin
        slot_request = |r.timer_w;
      end
      12: begin
        slot_request = |r.timer_v;
      end
      13: begin
        slot_request = |r.serial_unit;
      end
      14: begin
        slot_request = r.conv_end;
      end
      default: begin
        slot_request = 1'b0;
      end
    endcase
  endfunction : slot_request

  // Reset is not an interrupt, so flash lockout never holds it back
  function automatic logic slot_permit(
    input slot_class_type cls,
    input logic           mask,
    input logic           busy
  );
    case (cls)
      CLASS_RESET: begin
        slot_permit = 1'b1;
      end
      CLASS_UNMASKED: begin
        slot_permit = !busy;
      end
      CLASS_MASKABLE: begin
        slot_permit = !busy && !mask;
      end
      default: begin
        slot_permit = 1'b0;
      end
    endcase
  endfunction : slot_permit

  if (VECTOR_WIDTH != VEC_W) begin : g_bad_vector_width
    $error("Vector width must match the grant carrier");
  end
  if (ADDRESS_WIDTH != ADDR_W) begin : g_bad_address_width
    $error("Address width must match the grant carrier");
  end
  if (ADDRESS_WIDTH < VECTOR_WIDTH + 1) begin : g_narrow_address
    $error("Address must hold twice the largest vector number");
  end

  if (slot_vector(0) != VEC_RESET) begin : g_top_slot
    $error("Reset must sit in the top slot");
  end
  if (slot_vector(NUM_SLOTS - 1) != VEC_CONV_END) begin : g_lowest_slot
    $error("Conversion end must sit in the last slot");
  end

  // Table sanity, caught at elaboration rather than in the field
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_table_check
    if (is_reserved(slot_vector(s))) begin : g_reserved_hit
      $error("Slot maps onto a reserved vector");
    end
    if (vec_addr(slot_vector(s)) != {slot_vector(s), 1'b0}) begin : g_addr_hit
      $error("Vector address is not twice the number");
    end
    if ((s == 0) != (slot_class(s) == CLASS_RESET)) begin : g_reset_slot
      $error("Only the top slot may ignore the lockout");
    end
    if (s > 0) begin : g_order
      if (slot_vector(s) <= slot_vector(s - 1)) begin : g_order_broken
        $error("Slot order must follow vector order");
      end
      if (slot_class(s) < slot_class(s - 1)) begin : g_class_broken
        $error("A weaker class stands above a stronger one");
      end
    end
  end

  // Each slot is held back by any eligible slot above it
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
    assign raised[s]   = slot_request(req, s);
    assign allowed[s]  = slot_permit(slot_class(s), ccr_int_mask, flash_busy);
    assign eligible[s] = raised[s] && allowed[s];
    if (s == 0) begin : g_first
      assign taken_above[s] = 1'b0;
    end else begin : g_later
      assign taken_above[s] = taken_above[s - 1] || eligible[s - 1];
    end
    assign winner[s] = eligible[s] && !taken_above[s];
  end

  assign nxt_any = |winner;

  // Winner is one-hot, so an OR of the picked vectors is exact
  always_comb begin
    nxt_number = '0;
    for (int s = 0; s < NUM_SLOTS; s++) begin
      if (winner[s]) begin
        nxt_number = nxt_number | slot_vector(s);
      end
    end
  end

  always_comb begin
    nxt_grant         = '0;
    // Guard against a reserved number slipping out of a bad table edit
    nxt_grant.valid   = nxt_any && !is_reserved(nxt_number);
    nxt_grant.number  = nxt_number;
    nxt_grant.address = vec_addr(nxt_number);
  end

  // Registered so the core always fetches from a settled grant
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      grant_ff.valid   <= 1'b0;
      grant_ff.number  <= VEC_RST_VAL;
      grant_ff.address <= ADDR_RST_VAL;
    end else begin
      grant_ff.valid   <= nxt_grant.valid;
      grant_ff.number  <= nxt_grant.number;
      grant_ff.address <= nxt_grant.address;
    end
  end

endmodule : exception_vector_priority

// ---- tb/core_fetch_model.sv ----
`timescale 1ns/1ps
module core_fetch_model
  import vector_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire grant_type   grant_ff,
  output logic [ADDR_W-1:0] fetched_ff
);
  // Holds the last location fetched; idle grants leave it alone
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) fetched_ff <= ADDR_RST_VAL;
    else if (grant_ff.valid) fetched_ff <= grant_ff.address;
  end
endmodule : core_fetch_model

// ---- tb/exception_vector_checker.sv ----
`timescale 1ns/1ps
module exception_vector_checker
  import vector_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset_n,
  input wire request_type req,
  input wire logic        ccr_int_mask,
  input wire logic        flash_busy,
  input wire grant_type   grant_ff
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire [$bits(request_type)-1:0] rv = req;
  wire                           hi = |rv[$bits(request_type)-1:21];
  sequence s_open; !req.reset && !flash_busy; endsequence
  a_addr_twice: assert property (grant_ff.address == {10'h0, grant_ff.number, 1'b0})
    else $error("bad address");
  a_reset_top: assert property (req.reset |=> grant_ff.valid && grant_ff.number == 5'h00)
    else $error("reset lost");
  a_nmi_vec: assert property (s_open ##0 req.nmi |=> grant_ff.number == 5'h07)
    else $error("nmi vector");
  a_break_unmasked: assert property (s_open ##0 rv[27:22] == 6'h01 |=> grant_ff.number == 5'h0c)
    else $error("break vector");
  a_flash_blocks: assert property (flash_busy && !req.reset |=> !grant_ff.valid)
    else $error("flash leak");
  a_no_reserved: assert property (grant_ff.valid |-> !(grant_ff.number inside {[5'h01:5'h06], 5'h14}))
    else $error("reserved vector");
  a_conv_lowest: assert property (s_open ##0 !ccr_int_mask && rv == 1 |=> grant_ff.number == 5'h19)
    else $error("conv vector");
  a_mask_blocks: assert property (s_open ##0 ccr_int_mask && !hi |=> !grant_ff.valid)
    else $error("mask leak");
endmodule : exception_vector_checker
bind exception_vector_priority exception_vector_checker u_exception_vector_checker (.clock(clock), .reset_n(reset_n),
  .req(req), .ccr_int_mask(ccr_int_mask), .flash_busy(flash_busy), .grant_ff(grant_ff));

// ---- tb/exception_vector_priority_bench.sv ----
`timescale 1ns/1ps
module exception_vector_priority_bench;
  import vector_pkg::*;
  logic                          clock = 0, reset_n = 0, ccr_int_mask = 0, flash_busy = 0;
  logic [$bits(request_type)-1:0] one = 1;
  request_type                   req = '0;
  grant_type                     grant_ff;
  logic [ADDR_W-1:0]             fetched;
  int                            num_errors = 0, n_checks = 0;
  exception_vector_priority u_exception_vector_priority (.clock(clock), .reset_n(reset_n), .req(req),
    .ccr_int_mask(ccr_int_mask), .flash_busy(flash_busy), .grant_ff(grant_ff));
  core_fetch_model u_core_fetch_model (.clock(clock), .reset_n(reset_n), .grant_ff(grant_ff), .fetched_ff(fetched));
  initial begin
    forever #2 clock = ~clock;
  end
  function automatic grant_type g(logic [4:0] n, logic v = 1'b1);
    return '{v, n, {10'h0, n, 1'b0}};
  endfunction : g
  // Bit order follows the struct, lowest bit is conversion end
  function automatic logic [4:0] vn(int i);
    return i < 1 ? 25 : i < 5 ? 23 : i < 8 ? 22 : i < 13 ? 21 : i < 19 ? 18 : i == 19 ? 17 :
      i == 20 ? 14 : i == 21 ? 13 : i == 22 ? 12 : i < 27 ? i - 15 : i == 27 ? 7 : 0;
  endfunction : vn
  task automatic chk(request_type r, logic m, logic f, grant_type e);
    req = r; ccr_int_mask = m; flash_busy = f;
    @(posedge clock); #1;
    n_checks++;
    if (grant_ff !== e) begin
      num_errors++;
      $display("ERROR %0t grant %h want %h", $time, grant_ff, e);
    end
  endtask : chk
  task automatic chk_fetch(logic [ADDR_W-1:0] e);
    n_checks++;
    if (fetched !== e) begin
      num_errors++;
      $display("ERROR %0t fetch %h want %h", $time, fetched, e);
    end
  endtask : chk_fetch
  task automatic t_reset;
    chk(one << 5, 0, 0, g(22));
    chk(one << 5, 0, 0, g(22));
    chk_fetch(16'h002c);
    reset_n = 0;
    chk(one << 5, 0, 0, g(0, 0));
    chk_fetch(16'h0000);
    reset_n = 1;
    chk(one << 5, 0, 0, g(22));
    $display("t_reset done");
  endtask : t_reset
  task automatic t_vectors;
    for (int i = 0; i < $bits(request_type); i++) chk(one << i, 0, 0, g(vn(i)));
    $display("t_vectors done");
  endtask : t_vectors
  task automatic t_priority;
    chk('1, 0, 0, g(0));
    chk({1'b0, {28{1'b1}}}, 0, 0, g(7));
    chk(one << 24 | one << 26, 0, 0, g(9));
    chk(one << 1 | one, 0, 0, g(23));
    $display("t_priority done");
  endtask : t_priority
  task automatic t_masks;
    chk(one << 22 | one, 1, 0, g(12));
    chk(one << 13, 1, 0, g(0, 0));
    chk(one << 27, 0, 1, g(0, 0));
    chk(one << 28 | one << 27, 0, 1, g(0));
    $display("t_masks done");
  endtask : t_masks
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  initial begin
    #1000;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge clock);
    #1 reset_n = 1;
    t_vectors();
    t_priority();
    t_masks();
    t_reset();
    conclude();
  end
endmodule : exception_vector_priority_bench
